// >>> rtl/frpos_seq.sv
// hardware reset and power-on sequencer with axi4-lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "frpos_params.svh"

// Overview of operation
// - a reset pin low for ten microseconds or more fully resets the device
// - after reset: standby, volatile bits at defaults, 3-byte addressing
// - reset during program or erase aborts it at once; data may be lost
// - while reset is applied, output stays high impedance, lowest current
// - reset after power-on recovers within 35 us; no commands before that
// - reset during decoding or a read needs 40 us of recovery
// - reset during page program needs 310 us of recovery
// - erase recovery: 12 ms sector, 25 ms block, 1000 ms chip erase
// - reset during status register write needs 40 ms of recovery
// - power-up enters plain standby with the write enable latch cleared
// - below the supply threshold logic is held in reset, commands ignored
module frpos_seq import frpos_pkg::*; #(
   parameter int unsigned US_DIV = `FRPOS_CLK_HZ / `FRPOS_US_PER_S,
   parameter int unsigned RST_LOW_MIN_US = `FRPOS_RST_LOW_MIN_US,
   parameter int unsigned RST_TO_SEL_US = `FRPOS_RST_TO_SEL_US,
   parameter int unsigned PWRUP_REC_US = `FRPOS_PWRUP_REC_US,
   parameter int unsigned DECODE_REC_US = `FRPOS_DECODE_REC_US,
   parameter int unsigned READ_REC_US = `FRPOS_READ_REC_US,
   parameter int unsigned PROG_REC_US = `FRPOS_PROG_REC_US,
   parameter int unsigned SE4K_REC_US = `FRPOS_SE4K_REC_MS * `FRPOS_US_PER_MS,
   parameter int unsigned BE_REC_US = `FRPOS_BE_REC_MS * `FRPOS_US_PER_MS,
   parameter int unsigned CHIP_REC_US = `FRPOS_CHIP_REC_MS * `FRPOS_US_PER_MS,
   parameter int unsigned SW_REC_US = `FRPOS_SW_REC_MS * `FRPOS_US_PER_MS,
   parameter int unsigned SUPPLY_DLY_US = `FRPOS_SUPPLY_DLY_US,
   parameter logic [7:0] LOCK_DEFAULT = `FRPOS_LOCK_DEFAULT
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write channels
   input wire logic [`FRPOS_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [`FRPOS_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // flash pins and supply monitor
   input wire logic rst_pin_n,
   input wire logic cs_n,
   input wire logic supply_ok,
   // towards the flash core
   output logic dev_ready,
   output logic core_abort,
   output logic so_force_hiz,
   output logic low_power,
   output frpos_vol_s vol
);

   localparam int unsigned CW = 20;
   localparam logic [CW-1:0] L_LOW_MIN = CW'(RST_LOW_MIN_US);
   localparam logic [CW-1:0] L_TO_SEL = CW'(RST_TO_SEL_US);

   // ----------------------------------------------------------------
   // recovery length per interrupted operation
   // ----------------------------------------------------------------
   function automatic logic [CW-1:0] rec_us(input frpos_op_e op);
      logic [CW-1:0] r;
      r = CW'(DECODE_REC_US);
      unique case (op)
         OP_POWERUP: r = CW'(PWRUP_REC_US);
         OP_NONE, OP_DECODE: r = CW'(DECODE_REC_US);
         OP_READ: r = CW'(READ_REC_US);
         OP_PROGRAM: r = CW'(PROG_REC_US);
         OP_SECTOR_ERASE_4K: r = CW'(SE4K_REC_US);
         OP_BLOCK_ERASE_32K, OP_BLOCK_ERASE_64K: r = CW'(BE_REC_US);
         OP_CHIP_ERASE: r = CW'(CHIP_REC_US);
         OP_STATUS_WRITE_CMD: r = CW'(SW_REC_US);
         default: r = CW'(DECODE_REC_US);
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   frpos_state_e state, next_state;
   frpos_op_e op_reg, cap_op;
   logic por_fresh;
   logic tick;
   logic [CW-1:0] rem, low_us, since_rel;
   logic [1:0] flags;
   logic aw_got, w_got;
   logic [`FRPOS_AW-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_do, wr_vol, wr_ops, wr_flags, wr_ok;
   logic [31:0] next_rdata;
   logic next_rerr;
   logic [1:0] flag_set;
   logic done;

   frpos_tick #(
      .DIV(US_DIV)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(next_state != state),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // sequencing state machine
   // ----------------------------------------------------------------
   assign done = tick && (rem <= CW'(1));

   always_comb begin
      next_state = state;
      unique case (state)
         ST_POR: if (supply_ok) next_state = ST_VSL;
         ST_VSL: begin
            if (!rst_pin_n) next_state = ST_RST;
            else if (done) next_state = ST_READY;
         end
         ST_READY: if (!rst_pin_n) next_state = ST_RST;
         ST_RST: if (rst_pin_n) next_state = ST_RECOV;
         ST_RECOV: begin
            if (!rst_pin_n) next_state = ST_RST;
            else if (done) next_state = ST_READY;
         end
         default: next_state = ST_POR;
      endcase
      if (!supply_ok) next_state = ST_POR;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_POR;
      end else begin
         state <= next_state;
      end
   end

   // operation caught as the reset pin falls picks the recovery
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_op <= OP_POWERUP;
      end else if (next_state == ST_RST && state != ST_RST && state != ST_RECOV) begin
         cap_op <= (state == ST_VSL || por_fresh) ? OP_POWERUP : op_reg;
      end
   end

   // power-on counts as the last event until a command starts
   always_ff @(posedge aclk) begin
      if (!aresetn || state == ST_POR) begin
         por_fresh <= 1'b1;
      end else if (wr_ops && wr_ok && w_strb[0] && w_data[3:0] != OP_NONE) begin
         por_fresh <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rem <= '0;
      end else if (state == ST_POR && next_state == ST_VSL) begin
         rem <= CW'(SUPPLY_DLY_US);
      end else if (state == ST_RST && next_state == ST_RECOV) begin
         rem <= rec_us(cap_op);
      end else if (tick && rem != '0) begin
         rem <= rem - 1'b1;
      end
   end

   // pulse width and release-to-select timers, saturating
   always_ff @(posedge aclk) begin
      if (!aresetn || state != ST_RST) begin
         low_us <= '0;
      end else if (tick && low_us < L_LOW_MIN) begin
         low_us <= low_us + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || state != ST_RECOV) begin
         since_rel <= '0;
      end else if (tick && since_rel < L_TO_SEL) begin
         since_rel <= since_rel + 1'b1;
      end
   end

   // short pulses and early selects logged only; one tick slack for the divider restart
   always_comb begin
      flag_set = '0;
      flag_set[`FRPOS_FLAG_SHORT] = (state == ST_RST) && rst_pin_n
         && (low_us < L_LOW_MIN - CW'(1));
      flag_set[`FRPOS_FLAG_EARLY] = (state == ST_RECOV) && !cs_n
         && (since_rel < L_TO_SEL - CW'(1));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= '0;
      end else if (wr_flags && wr_ok && w_strb[0]) begin
         flags <= (flags & ~w_data[1:0]) | flag_set;
      end else begin
         flags <= flags | flag_set;
      end
   end

   // ----------------------------------------------------------------
   // outputs to the core
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dev_ready <= 1'b0;
         core_abort <= 1'b1;
      end else begin
         dev_ready <= (next_state == ST_READY);
         core_abort <= (next_state != ST_READY);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         so_force_hiz <= 1'b1;
         low_power <= 1'b1;
      end else begin
         so_force_hiz <= (next_state != ST_READY);
         low_power <= (next_state == ST_RST || next_state == ST_POR);
      end
   end

   // volatile bits return to power-on defaults, 3-byte addressing
   always_ff @(posedge aclk) begin
      if (!aresetn || state == ST_POR || state == ST_RST) begin
         vol <= '{sram_lock: LOCK_DEFAULT, addr_4b: 1'b0,
                  write_in_progress: 1'b0, write_enable_latch: 1'b0};
      end else if (wr_vol && wr_ok) begin
         if (w_strb[0]) begin
            vol.addr_4b <= w_data[2];
            vol.write_in_progress <= w_data[1];
            vol.write_enable_latch <= w_data[0];
         end
         if (w_strb[1]) begin
            vol.sram_lock <= w_data[15:8];
         end
      end
   end

   // an aborted operation is gone; unknown codes read as idle
   always_ff @(posedge aclk) begin
      if (!aresetn || state == ST_POR || state == ST_RST) begin
         op_reg <= OP_NONE;
      end else if (wr_ops && wr_ok && w_strb[0]) begin
         if (w_data[3:0] < OP_POWERUP) begin
            op_reg <= frpos_op_e'(w_data[3:0]);
         end else begin
            op_reg <= OP_NONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write path
   // ----------------------------------------------------------------
   assign wr_do = aw_got && w_got && !s_axi_bvalid;
   assign wr_vol = wr_do && (aw_addr == `FRPOS_OFF_VOL);
   assign wr_ops = wr_do && (aw_addr == `FRPOS_OFF_OPS);
   assign wr_flags = wr_do && (aw_addr == `FRPOS_OFF_FLAGS);
   // commands stand for the core and are refused with SLVERR until recovery ends; flag writes always pass
   assign wr_ok = wr_flags || (state == ST_READY && (wr_vol || wr_ops));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         s_axi_awready <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got <= 1'b1;
         s_axi_awready <= 1'b0;
         aw_addr <= s_axi_awaddr;
      end else if (wr_do) begin
         aw_got <= 1'b0;
      end else if (!aw_got && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got <= 1'b0;
         s_axi_wready <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got <= 1'b1;
         s_axi_wready <= 1'b0;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_do) begin
         w_got <= 1'b0;
      end else if (!w_got && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FRPOS_RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? `FRPOS_RESP_OKAY : `FRPOS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read path
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = '0;
      next_rerr = 1'b0;
      unique case (s_axi_araddr)
         `FRPOS_OFF_VOL: next_rdata = {21'h0, vol};
         `FRPOS_OFF_OPS: next_rdata = {28'h0, op_reg};
         `FRPOS_OFF_STAT: next_rdata = {23'h0, por_fresh, cap_op, dev_ready, state};
         `FRPOS_OFF_FLAGS: next_rdata = {30'h0, flags};
         `FRPOS_OFF_REMAIN: next_rdata = {12'h0, rem};
         default: next_rerr = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `FRPOS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rerr ? `FRPOS_RESP_SLVERR : `FRPOS_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// >>> inc/frpos_params.svh
// constants of the flash reset and power-on sequencer
`ifndef FRPOS_PARAMS_SVH
`define FRPOS_PARAMS_SVH

// ----------------------------------------------------------------
// clock and time units
// ----------------------------------------------------------------
`define FRPOS_CLK_HZ 20000000
`define FRPOS_US_PER_S 1000000
`define FRPOS_US_PER_MS 1000

// ----------------------------------------------------------------
// reset and power-on timing, in the unit of the name
// ----------------------------------------------------------------
`define FRPOS_RST_LOW_MIN_US 10
`define FRPOS_RST_TO_SEL_US 10
`define FRPOS_PWRUP_REC_US 35
`define FRPOS_DECODE_REC_US 40
`define FRPOS_READ_REC_US 40
`define FRPOS_PROG_REC_US 310
`define FRPOS_SE4K_REC_MS 12
`define FRPOS_BE_REC_MS 25
`define FRPOS_CHIP_REC_MS 1000
`define FRPOS_SW_REC_MS 40
`define FRPOS_SUPPLY_DLY_US 100

// ----------------------------------------------------------------
// register map (byte addresses) and answers
// ----------------------------------------------------------------
`define FRPOS_AW 8
`define FRPOS_OFF_VOL 8'h00
`define FRPOS_OFF_OPS 8'h04
`define FRPOS_OFF_STAT 8'h08
`define FRPOS_OFF_FLAGS 8'h0C
`define FRPOS_OFF_REMAIN 8'h10
`define FRPOS_RESP_OKAY 2'h0
`define FRPOS_RESP_SLVERR 2'h2
`define FRPOS_FLAG_SHORT 0
`define FRPOS_FLAG_EARLY 1
`define FRPOS_LOCK_DEFAULT 8'h00

`endif

// >>> inc/frpos_pkg.sv
// types of the flash reset and power-on sequencer
package frpos_pkg;

   // gray along por -> supply wait -> ready -> reset -> recovery
   typedef enum logic [2:0] {
      ST_POR = 3'h0,
      ST_VSL = 3'h1,
      ST_READY = 3'h3,
      ST_RST = 3'h2,
      ST_RECOV = 3'h6
   } frpos_state_e;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_DECODE = 4'h1,
      OP_READ = 4'h2,
      OP_PROGRAM = 4'h3,
      OP_SECTOR_ERASE_4K = 4'h4,
      OP_BLOCK_ERASE_32K = 4'h5,
      OP_BLOCK_ERASE_64K = 4'h6,
      OP_CHIP_ERASE = 4'h7,
      OP_STATUS_WRITE_CMD = 4'h8,
      OP_POWERUP = 4'h9
   } frpos_op_e;

   typedef struct packed {
      logic [7:0] sram_lock;
      logic addr_4b;
      logic write_in_progress;
      logic write_enable_latch;
   } frpos_vol_s;

endpackage

// >>> rtl/frpos_tick.sv
// microsecond tick divider for the reset sequencer
`timescale 1ns/1ps
`default_nettype none

module frpos_tick #(
   parameter int unsigned DIV = 20
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // restart and tick
   input wire logic clr,
   output logic tick
);

   localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt;

   // restart makes the first tick a full period after the restart,
   // so a least time counted in ticks never comes out short
   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         cnt <= '0;
      end else if (cnt == LAST) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         tick <= 1'b0;
      end else begin
         tick <= (cnt == LAST);
      end
   end

endmodule

`default_nettype wire

// >>> dv/frpos_host_model.sv
// host-side model driving the flash reset pin and chip select
`timescale 1ns/1ps
`default_nettype none

module frpos_host_model #(
   parameter int unsigned US_DIV = 20,
   parameter int unsigned LOW_US = 10,
   parameter int unsigned SEL_US = 10
) (
   // clock and supply
   input wire logic aclk,
   input wire logic supply_ok,
   // requests from the bench
   input wire logic go,
   input wire logic sel,
   // pins towards the device
   output logic rst_pin_n,
   output logic cs_n,
   // one-cycle mark at reset release
   output logic rel
);
   logic rst_q = 1'b1;
   logic rel_q = 1'b0;
   int unsigned low_cnt = 0;
   int unsigned lock_cnt = 0;

   always @(posedge aclk) begin
      rel_q <= 1'b0;
      if (lock_cnt != 0) lock_cnt <= lock_cnt - 1;
      if (low_cnt != 0) begin
         low_cnt <= low_cnt - 1;
         if (low_cnt == 1) begin
            rst_q <= 1'b1;
            rel_q <= 1'b1;
            lock_cnt <= SEL_US * US_DIV;
         end
      end else if (go) begin
         rst_q <= 1'b0;
         low_cnt <= LOW_US * US_DIV;
      end
   end

   assign rst_pin_n = rst_q;
   assign rel = rel_q;
   // select is refused while supply is low or too soon after release
   assign cs_n = !(sel && supply_ok && rst_q && lock_cnt == 0);
endmodule

`default_nettype wire

// >>> dv/frpos_seq_monitor.sv
// assertion checker for the flash reset and power-on sequencer
`timescale 1ns/1ps
`default_nettype none

module frpos_seq_monitor import frpos_pkg::*; #(
   parameter int unsigned US_DIV = 20,
   parameter int unsigned PWRUP_REC_US = 35,
   parameter int unsigned MAX_REC_US = 1000000
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   // pins and core side
   input wire logic rst_pin_n,
   input wire logic supply_ok,
   input wire logic dev_ready,
   input wire logic core_abort,
   input wire logic so_force_hiz,
   input wire logic low_power,
   input wire frpos_vol_s vol
);
   localparam int unsigned MIN_CYC = PWRUP_REC_US * US_DIV - 1;
   localparam int unsigned MAX_CYC = MAX_REC_US * US_DIV + 3;
   int unsigned rec_cnt;
   logic seen_rst;

   // cycles since the pin went high or the supply came up while the device is still recovering
   always_ff @(posedge aclk) begin
      if (!aresetn || !supply_ok || !rst_pin_n || dev_ready) rec_cnt <= 0;
      else rec_cnt <= rec_cnt + 1;
   end
   // power-up path has its own delay, so only pin resets get the minimum
   always_ff @(posedge aclk) begin
      if (!aresetn || !supply_ok) seen_rst <= 1'b0;
      else if (!rst_pin_n) seen_rst <= 1'b1;
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_ABORT_TIES: assert property (core_abort == !dev_ready)
      else $error("core abort does not mirror not-ready");
   // from power-on the pin is obeyed one state later, so two low samples come first
   AST_RST_ENTRY: assert property ((!rst_pin_n && supply_ok) [*2] ##1 !rst_pin_n |->
      core_abort && so_force_hiz && low_power && !dev_ready)
      else $error("reset pin low without abort, hiz and low power");
   AST_READY_CLEAN: assert property (dev_ready |-> !so_force_hiz && !low_power)
      else $error("ready while output forced or in low power");
   // volatile bits clear one cycle after ready drops
   AST_VOL_DEFAULT: assert property (!dev_ready [*2] |-> vol == '0)
      else $error("volatile bits not at defaults while not ready");
   AST_LOWPWR_EXIT: assert property ($rose(rst_pin_n) && supply_ok && low_power |->
      ##[1:2] !low_power)
      else $error("low power kept after reset pin release");
   AST_POR_HOLD: assert property (!supply_ok [*2] |-> !dev_ready && low_power)
      else $error("device active while supply is low");
   AST_REC_MIN: assert property ($rose(dev_ready) && seen_rst |->
      rec_cnt >= MIN_CYC)
      else $error("recovery shorter than the least allowed");
   AST_REC_MAX: assert property (rec_cnt <= MAX_CYC)
      else $error("recovery runs past the longest allowed");
   AST_BVALID_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated after acceptance");
   AST_RERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == '0)
      else $error("refused read carries nonzero data");

   cover property ($rose(dev_ready) && seen_rst);
   cover property (!supply_ok ##1 supply_ok);
   cover property (s_axi_bvalid && !dev_ready);
endmodule

bind frpos_seq frpos_seq_monitor #(
   .US_DIV(US_DIV), .PWRUP_REC_US(PWRUP_REC_US),
   .MAX_REC_US(CHIP_REC_US + SW_REC_US + BE_REC_US + SE4K_REC_US + PROG_REC_US
      + READ_REC_US + DECODE_REC_US + PWRUP_REC_US + SUPPLY_DLY_US)
) u_mon (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .rst_pin_n(rst_pin_n), .supply_ok(supply_ok), .dev_ready(dev_ready),
   .core_abort(core_abort), .so_force_hiz(so_force_hiz), .low_power(low_power), .vol(vol)
);

`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the flash reset and power-on sequencer
`timescale 1ns/1ps
`default_nettype none
`include "frpos_params.svh"

module testbench import frpos_pkg::*;;
   localparam int DIV = 4;
   // recovery in microseconds by operation code; erases and status write shortened
   localparam int REC_US [9] = '{40, 40, 40, 310, 50, 60, 60, 70, 80};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic supply_ok = 1'b0, go = 1'b0, sel = 1'b0;
   logic rst_pin_n, cs_n, rel, dev_ready, core_abort, so_force_hiz, low_power;
   logic [31:0] d;
   frpos_vol_s vol;
   int err_count = 0;
   int checked = 0;

   always #25 aclk = ~aclk;

   frpos_host_model #(.US_DIV(DIV)) u_host (.aclk(aclk), .supply_ok(supply_ok), .go(go),
      .sel(sel), .rst_pin_n(rst_pin_n), .cs_n(cs_n), .rel(rel));

   frpos_seq #(.US_DIV(DIV), .SE4K_REC_US(50), .BE_REC_US(60), .CHIP_REC_US(70),
      .SW_REC_US(80), .SUPPLY_DLY_US(5)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rst_pin_n(rst_pin_n),
      .cs_n(cs_n), .supply_ok(supply_ok), .dev_ready(dev_ready), .core_abort(core_abort),
      .so_force_hiz(so_force_hiz), .low_power(low_power), .vol(vol));

   task automatic tally_and_finish;
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // a used-up bound counts as a mismatch and closes the run
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         err_count++;
         tally_and_finish();
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
      int n;
      n = 0;
      rs = 2'h3;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end while (rs === 2'h3 && n < 200);
      guard(n, 200);
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
      int n;
      n = 0;
      rs = 2'h3;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end while (rs === 2'h3 && n < 200);
      guard(n, 200);
   endtask

   // waits for ready and compares the elapsed cycles with the expected window
   task automatic wait_ready(input time t0, input int exp);
      int n;
      int cyc;
      n = 0;
      while (dev_ready !== 1'b1 && n < 2000) begin
         @(posedge aclk);
         n++;
      end
      guard(n, 2000);
      cyc = int'(($time - t0) / 50);
      check(32'(cyc >= exp && cyc <= exp + 5), 32'h1);
   endtask

   task automatic rst_cycle(input int us);
      int n;
      time t0;
      n = 0;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (3) @(posedge aclk);
      check(32'({dev_ready, core_abort, so_force_hiz, low_power}), 32'h7);
      check(32'(vol), 32'h0);
      while (rel !== 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      guard(n, 100);
      t0 = $time;
      repeat (3) @(posedge aclk);
      check(32'(low_power), 32'h0);
      axi_write(`FRPOS_OFF_VOL, 32'h7FF, r);
      check(32'(r), 32'(`FRPOS_RESP_SLVERR));
      wait_ready(t0, us * DIV);
      check(32'(vol), 32'h0);
   endtask

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      check(32'({dev_ready, low_power}), 32'h1);
      supply_ok <= 1'b1;
      @(posedge aclk);
      wait_ready($time, 5 * DIV);
      check(32'(vol), 32'h0);
      // the lock byte rides in the second lane, so all eleven bits come out set
      axi_write(`FRPOS_OFF_VOL, 32'hFF07, r);
      check(32'(r), 32'(`FRPOS_RESP_OKAY));
      check(32'(vol), 32'h7FF);
      axi_read(`FRPOS_OFF_STAT, d, r);
      check(32'(d[3:0]), 32'hB);
      // no operation written yet, so the power-on recovery applies; the host
      // selects as soon as its release lock allows, which is on time, not early
      sel <= 1'b1;
      rst_cycle(35);
      sel <= 1'b0;
      axi_read(`FRPOS_OFF_FLAGS, d, r);
      check(d, 32'h0);
      for (int op = 1; op < 9; op++) begin
         axi_write(`FRPOS_OFF_OPS, 32'(op), r);
         axi_write(`FRPOS_OFF_VOL, 32'hFF07, r);
         check(32'(vol), 32'h7FF);
         rst_cycle(REC_US[op]);
      end
      axi_write(`FRPOS_OFF_OPS, 32'h9, r);
      axi_read(`FRPOS_OFF_OPS, d, r);
      check(d, 32'h0);
      axi_read(8'h14, d, r);
      check(32'(r), 32'(`FRPOS_RESP_SLVERR));
      check(d, 32'h0);
      axi_write(`FRPOS_OFF_STAT, 32'h1, r);
      check(32'(r), 32'(`FRPOS_RESP_SLVERR));
      tally_and_finish();
   end
endmodule

`default_nettype wire
